//--- include/wwd_pkg.sv
package wwd_pkg;

  // Register bus geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 32;

  // Byte offsets of the registers
  localparam logic [3:0] OFS_RESTART_CONTROL = 4'h0;
  localparam logic [3:0] OFS_WATCHDOG_MODE = 4'h4;
  localparam logic [3:0] OFS_WATCHDOG_STATUS = 4'h8;

  // Restart control fields
  localparam int unsigned KEY_LSB = 24;
  localparam int unsigned KEY_W = 8;
  localparam logic [7:0] RESTART_KEY = 8'ha5;
  localparam int unsigned RESTART_COMMAND_BIT = 0;

  // Mode register fields
  localparam int unsigned CNT_W = 12;
  localparam int unsigned RELOAD_LEVEL_LSB = 0;
  localparam int unsigned FAULT_INT_EN_BIT = 12;
  localparam int unsigned FAULT_RST_EN_BIT = 13;
  localparam int unsigned PROC_ONLY_BIT = 14;
  localparam int unsigned DISABLE_BIT = 15;
  localparam int unsigned WINDOW_DELTA_LSB = 16;
  localparam int unsigned DEBUG_HALT_BIT = 28;
  localparam int unsigned IDLE_HALT_BIT = 29;
  localparam logic [31:0] MODE_RESET = 32'h3fff_2fff;
  localparam logic [31:0] MODE_MASK = 32'h3fff_ffff;

  // Status register fields
  localparam int unsigned UNDERFLOW_BIT = 0;
  localparam int unsigned EARLY_ERROR_BIT = 1;

  // Prescaler on the slow clock
  localparam int unsigned SLOW_DIV = 128;

  // Register bus handshake states
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ACK = 1'b1
  } wwd_bus_e;

endpackage : wwd_pkg

//--- core/wwd_prescaler.sv
`timescale 1ns/10ps
module wwd_prescaler #(
  parameter int unsigned DIV = 128
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_restart,
  input wire logic i_slow_edge,
  // Divided tick
  output logic o_tick
);

  localparam int unsigned PW = (DIV < 2) ? 1 : $clog2(DIV);
  localparam logic [PW-1:0] LAST = PW'(DIV - 1);

  if (DIV < 2) begin : g_bad_div
    $error("prescaler divide must be at least 2");
  end

  logic [PW-1:0] pre_ff;
  logic tick_ff;

  // Restart clears the partial period too
  always_ff @(posedge i_clk) begin
    if (i_rst || i_restart) begin
      pre_ff <= '0;
      tick_ff <= 1'b0;
    end else if (i_slow_edge) begin
      if (pre_ff == LAST) begin
        pre_ff <= '0;
        tick_ff <= 1'b1;
      end else begin
        pre_ff <= pre_ff + 1'b1;
        tick_ff <= 1'b0;
      end
    end else begin
      tick_ff <= 1'b0;
    end
  end

  assign o_tick = tick_ff;

endmodule : wwd_prescaler

//--- core/wwd_top.sv
// What this block does
// - Twelve-bit down counter reloads from the mode counter field.
// - Counter steps once per slow clock divided by 128.
// - Counter field resets to all ones; watchdog runs with resets enabled.
// - Mode register takes only its first write after processor reset.
// - Writing the mode register reloads and restarts the counter.
// - Valid restart reloads counter and restarts the prescaler.
// - Control writes need key 0xA5 in bits 31..24, else discarded.
// - Underflow sets sticky flag and fault line when resets enabled.
// - Restart above delta sets error and fault instead; works even disabled.
// - Delta not below counter value accepts every restart.
// - Flags raise interrupt only with fault interrupt enable set.
// - Status read or reset clears flags, interrupt and fault line.
// - Watchdog reset resets processor and this block with its flags.
// - Processor-only select picks processor reset, else all resets.
// - Reset enable clear means faults request no reset.
// - Debug halt bit stops the counter in debug state.
// - Idle halt bit stops the counter in idle mode.
// - Disable bit stops the counter; clearing it enables it.
// - Mode holds value in 11..0, delta in 27..16, resets 0x3FFF_2FFF.
// - Status bit 0 underflow, bit 1 error, since last status read.
`timescale 1ns/10ps
module wwd_top #(
  parameter int unsigned PRE_DIV = wwd_pkg::SLOW_DIV
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,

  // Avalon-MM slave
  input wire logic [wwd_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [wwd_pkg::DATA_W-1:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [wwd_pkg::DATA_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,

  // Slow clock and processor state pins
  input wire logic i_slow_clk,
  input wire logic i_debug_state,
  input wire logic i_idle_mode,

  // Towards interrupt and reset controllers
  output logic o_irq,
  output logic o_fault,
  output logic o_reset_all_req,
  output logic o_reset_proc_req,

  // Counter observation
  output logic [wwd_pkg::CNT_W-1:0] o_count
);

  localparam int unsigned NPIN = 3;
  localparam int unsigned PIN_SLOW = 0;
  localparam int unsigned PIN_DEBUG = 1;
  localparam int unsigned PIN_IDLE = 2;

  if (PRE_DIV < 2) begin : g_bad_pre
    $error("slow clock divide must be at least 2");
  end

  // Pin synchronisers
  logic [NPIN-1:0] pin_in;
  logic [NPIN-1:0] pin_lvl;
  logic [NPIN-1:0] pin_rise;

  assign pin_in = {i_idle_mode, i_debug_state, i_slow_clk};

  for (genvar p = 0; p < NPIN; p++) begin : g_pin
    logic [2:0] sync_ff;
    logic lvl_ff;
    logic agree;

    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        sync_ff <= 3'h0;
      end else begin
        sync_ff <= {sync_ff[1:0], pin_in[p]};
      end
    end

    // Glitch guard: stages two and three must agree
    assign agree = (sync_ff[1] == sync_ff[2]);

    always_ff @(posedge i_clk) begin
      if (i_rst) begin
        lvl_ff <= 1'b0;
      end else if (agree) begin
        lvl_ff <= sync_ff[2];
      end
    end

    assign pin_lvl[p] = lvl_ff;
    assign pin_rise[p] = agree && sync_ff[2] && !lvl_ff;
  end

  // Bus handshake: one wait cycle per access
  wwd_pkg::wwd_bus_e bus_state_ff;
  logic bus_req;
  logic bus_take;
  logic wr_take;
  logic rd_take;
  logic rd_first;

  assign bus_req = i_avs_read || i_avs_write;
  assign bus_take = bus_req && (bus_state_ff == wwd_pkg::BUS_ACK);
  assign o_avs_waitrequest = bus_req && (bus_state_ff != wwd_pkg::BUS_ACK);
  assign wr_take = bus_take && i_avs_write;
  assign rd_take = bus_take && i_avs_read;
  assign rd_first = i_avs_read && (bus_state_ff == wwd_pkg::BUS_IDLE);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      bus_state_ff <= wwd_pkg::BUS_IDLE;
    end else begin
      case (bus_state_ff)
        wwd_pkg::BUS_IDLE: begin
          if (bus_req) begin
            bus_state_ff <= wwd_pkg::BUS_ACK;
          end
        end
        wwd_pkg::BUS_ACK: begin
          bus_state_ff <= wwd_pkg::BUS_IDLE;
        end
        default: begin
          bus_state_ff <= wwd_pkg::BUS_IDLE;
        end
      endcase
    end
  end

  // Address decode
  logic sel_ctrl;
  logic sel_mode;
  logic sel_stat;

  always_comb begin
    sel_ctrl = 1'b0;
    sel_mode = 1'b0;
    sel_stat = 1'b0;
    if (i_avs_address == wwd_pkg::OFS_RESTART_CONTROL) begin
      sel_ctrl = 1'b1;
    end else if (i_avs_address == wwd_pkg::OFS_WATCHDOG_MODE) begin
      sel_mode = 1'b1;
    end else if (i_avs_address == wwd_pkg::OFS_WATCHDOG_STATUS) begin
      sel_stat = 1'b1;
    end
  end

  // Mode register, write once
  logic [31:0] mode_ff;
  logic [31:0] nxt_mode;
  logic mode_locked_ff;
  logic mode_write;

  assign mode_write = wr_take && sel_mode && !mode_locked_ff;

  always_comb begin
    nxt_mode = mode_ff;
    for (int b = 0; b < 4; b++) begin
      if (i_avs_byteenable[b]) begin
        nxt_mode[8*b +: 8] = i_avs_writedata[8*b +: 8];
      end
    end
    nxt_mode = nxt_mode & wwd_pkg::MODE_MASK;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      mode_ff <= wwd_pkg::MODE_RESET;
      mode_locked_ff <= 1'b0;
    end else if (mode_write) begin
      mode_ff <= nxt_mode;
      mode_locked_ff <= 1'b1;
    end
  end

  // Mode fields
  logic [wwd_pkg::CNT_W-1:0] counter_reload_level;
  logic [wwd_pkg::CNT_W-1:0] restart_window_delta;
  logic [wwd_pkg::CNT_W-1:0] new_reload_level;
  logic fault_interrupt_enable;
  logic fault_reset_enable;
  logic processor_only_reset_select;
  logic watchdog_disable;
  logic debug_halt_enable;
  logic idle_halt_enable;

  assign counter_reload_level = mode_ff[wwd_pkg::RELOAD_LEVEL_LSB +: wwd_pkg::CNT_W];
  assign restart_window_delta = mode_ff[wwd_pkg::WINDOW_DELTA_LSB +: wwd_pkg::CNT_W];
  assign new_reload_level = nxt_mode[wwd_pkg::RELOAD_LEVEL_LSB +: wwd_pkg::CNT_W];
  assign fault_interrupt_enable = mode_ff[wwd_pkg::FAULT_INT_EN_BIT];
  assign fault_reset_enable = mode_ff[wwd_pkg::FAULT_RST_EN_BIT];
  assign processor_only_reset_select = mode_ff[wwd_pkg::PROC_ONLY_BIT];
  assign watchdog_disable = mode_ff[wwd_pkg::DISABLE_BIT];
  assign debug_halt_enable = mode_ff[wwd_pkg::DEBUG_HALT_BIT];
  assign idle_halt_enable = mode_ff[wwd_pkg::IDLE_HALT_BIT];

  // Restart command
  logic key_ok;
  logic restart_command_bit;
  logic restart_cmd;
  logic restart_early;
  logic restart_ok;
  logic [wwd_pkg::CNT_W-1:0] count_ff;

  assign key_ok = i_avs_byteenable[3]
      && (i_avs_writedata[wwd_pkg::KEY_LSB +: wwd_pkg::KEY_W] == wwd_pkg::RESTART_KEY);
  assign restart_command_bit = i_avs_byteenable[0]
      && i_avs_writedata[wwd_pkg::RESTART_COMMAND_BIT];
  assign restart_cmd = wr_take && sel_ctrl && key_ok && restart_command_bit;

  // delta at or above value never trips
  assign restart_early = restart_cmd && (count_ff > restart_window_delta);
  assign restart_ok = restart_cmd && !restart_early;

  // Prescaler
  logic pre_tick;
  logic pre_restart;

  assign pre_restart = restart_ok || mode_write;

  wwd_prescaler #(
    .DIV(PRE_DIV)
  ) wwd_prescaler_i (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_restart(pre_restart),
    .i_slow_edge(pin_rise[PIN_SLOW]),
    .o_tick(pre_tick)
  );

  // Run condition
  logic run;
  logic underflow_evt;

  assign run = !watchdog_disable
      && !(pin_lvl[PIN_DEBUG] && debug_halt_enable)
      && !(pin_lvl[PIN_IDLE] && idle_halt_enable);

  assign underflow_evt = pre_tick && run && (count_ff == '0);

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count_ff <= wwd_pkg::MODE_RESET[wwd_pkg::RELOAD_LEVEL_LSB +: wwd_pkg::CNT_W];
    end else if (mode_write) begin
      count_ff <= new_reload_level;
    end else if (restart_ok) begin
      count_ff <= counter_reload_level;
    end else if (pre_tick && run) begin
      if (count_ff == '0) begin
        count_ff <= counter_reload_level;
      end else begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

  assign o_count = count_ff;

  // Sticky status; set wins over a clearing read
  logic sr_read;
  logic underflow_flag_ff;
  logic early_restart_error_flag_ff;
  logic fault_ff;
  logic nxt_underflow;
  logic nxt_error;
  logic nxt_fault;

  assign sr_read = rd_take && sel_stat;

  assign nxt_underflow = (underflow_flag_ff && !sr_read) || underflow_evt;
  assign nxt_error = (early_restart_error_flag_ff && !sr_read) || restart_early;

  assign nxt_fault = (fault_ff && !sr_read)
      || (underflow_evt && fault_reset_enable)
      || restart_early;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      underflow_flag_ff <= 1'b0;
      early_restart_error_flag_ff <= 1'b0;
      fault_ff <= 1'b0;
    end else begin
      underflow_flag_ff <= nxt_underflow;
      early_restart_error_flag_ff <= nxt_error;
      fault_ff <= nxt_fault;
    end
  end

  // Interrupt and reset requests
  logic irq_ff;
  logic reset_all_ff;
  logic reset_proc_ff;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      irq_ff <= 1'b0;
      reset_all_ff <= 1'b0;
      reset_proc_ff <= 1'b0;
    end else begin
      irq_ff <= fault_interrupt_enable && (nxt_underflow || nxt_error);
      reset_all_ff <= nxt_fault && fault_reset_enable && !processor_only_reset_select;
      reset_proc_ff <= nxt_fault && fault_reset_enable;
    end
  end

  assign o_irq = irq_ff;
  assign o_fault = fault_ff;
  assign o_reset_all_req = reset_all_ff;
  assign o_reset_proc_req = reset_proc_ff;

  // Read data, captured in the wait cycle
  logic [31:0] rdata_ff;
  logic [31:0] status_word;

  // Includes events landing in the capture cycle
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[wwd_pkg::UNDERFLOW_BIT] = nxt_underflow;
    status_word[wwd_pkg::EARLY_ERROR_BIT] = nxt_error;
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rdata_ff <= 32'h0000_0000;
    end else if (rd_first) begin
      if (sel_mode) begin
        rdata_ff <= mode_ff;
      end else if (sel_stat) begin
        rdata_ff <= status_word;
      end else begin
        rdata_ff <= 32'h0000_0000;
      end
    end
  end

  assign o_avs_readdata = rdata_ff;

endmodule : wwd_top

//--- bench/wwd_top_asserts.sv
`timescale 1ns/10ps
module wwd_top_asserts #(
  parameter int unsigned PRE_DIV = 128
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Register bus
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] o_avs_readdata,
  input wire logic o_avs_waitrequest,
  // Pins and outputs
  input wire logic i_slow_clk,
  input wire logic i_debug_state,
  input wire logic i_idle_mode,
  input wire logic o_irq,
  input wire logic o_fault,
  input wire logic o_reset_all_req,
  input wire logic o_reset_proc_req,
  input wire logic [11:0] o_count
);
  logic acc;
  logic wacc;
  logic srd;
  logic ctl_bad;
  assign acc = (i_avs_read || i_avs_write) && !o_avs_waitrequest;
  assign wacc = acc && i_avs_write;
  assign srd = acc && i_avs_read && i_avs_address == 4'h8;
  assign ctl_bad = wacc && i_avs_address == 4'h0 && i_avs_writedata[31:24] != 8'ha5;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Count moves only by single steps unless written or reloading at zero
  AST_TICK_STEP: assert property (
    !$past(i_rst) && !$past(wacc) && $past(o_count) != 12'h0 && $changed(o_count)
    |-> o_count == $past(o_count) - 12'h1) else $error("count jumped");
  AST_BAD_KEY: assert property (
    ctl_bad && o_count != 12'h0 |=> !$rose(o_fault) && o_count <= $past(o_count))
    else $error("bad key acted");
  AST_SR_CLEAR: assert property (
    srd && o_count != 12'h0 |=> !o_fault && !o_irq) else $error("status read kept fault");
  AST_FAULT_HOLD: assert property (
    o_fault && !srd |=> o_fault) else $error("fault dropped early");
  AST_ALL_REQ: assert property (
    o_reset_all_req |-> o_reset_proc_req && o_fault) else $error("all reset without fault");
  AST_PROC_REQ: assert property (
    o_reset_proc_req |-> o_fault) else $error("reset request without fault");
  // Reset itself must clear outputs, so no disable here
  AST_RST_STATE: assert property (disable iff (1'b0)
    i_rst |=> !o_fault && !o_irq && !o_reset_proc_req && o_count == 12'hfff)
    else $error("reset state wrong");
  AST_SR_BITS: assert property (
    srd |-> o_avs_readdata[31:2] == 30'h0) else $error("status upper bits set");
  AST_MODE_BITS: assert property (
    acc && i_avs_read && i_avs_address == 4'h4 |-> o_avs_readdata[31:30] == 2'b00)
    else $error("mode upper bits set");
  cover property (srd && o_fault);
  cover property (o_reset_all_req);
  cover property ($rose(o_reset_proc_req) && !o_reset_all_req);
endmodule : wwd_top_asserts

bind wwd_top wwd_top_asserts #(.PRE_DIV(PRE_DIV)) wwd_top_asserts_i (.i_clk, .i_rst,
  .i_avs_address, .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
  .o_avs_readdata, .o_avs_waitrequest, .i_slow_clk, .i_debug_state, .i_idle_mode,
  .o_irq, .o_fault, .o_reset_all_req, .o_reset_proc_req, .o_count);

//--- bench/wwd_rstc_model.sv
`timescale 1ns/10ps
module wwd_rstc_model (
  // Clock
  input wire logic i_clk,
  // Requests from the watchdog
  input wire logic i_reset_all_req,
  input wire logic i_reset_proc_req,
  // Back towards the chip
  output logic o_slow_clk,
  output logic o_wd_rst,
  output logic [7:0] o_all_cnt,
  output logic [7:0] o_proc_cnt
);
  logic [2:0] div_ff = 3'h0;
  logic req_ff = 1'b0;
  logic [1:0] hold_ff = 2'h0;
  logic [7:0] all_ff = 8'h0;
  logic [7:0] proc_ff = 8'h0;
  // Slow clock runs free, eight fast cycles a period
  always_ff @(posedge i_clk) div_ff <= div_ff + 3'h1;
  assign o_slow_clk = div_ff[2];
  always_ff @(posedge i_clk) begin
    req_ff <= i_reset_proc_req;
    if (i_reset_proc_req && !req_ff) begin
      hold_ff <= 2'h3;
    end else if (hold_ff != 2'h0) begin
      hold_ff <= hold_ff - 2'h1;
    end
  end
  assign o_wd_rst = hold_ff != 2'h0;
  always_ff @(posedge i_clk) begin
    if (i_reset_proc_req && !req_ff) begin
      all_ff <= all_ff + {7'h0, i_reset_all_req};
      proc_ff <= proc_ff + {7'h0, !i_reset_all_req};
    end
  end
  assign o_all_cnt = all_ff;
  assign o_proc_cnt = proc_ff;
endmodule : wwd_rstc_model

//--- bench/wwd_top_tb.sv
`timescale 1ns/10ps
module wwd_top_tb;
  logic i_clk = 1'b0;
  logic por = 1'b1;
  logic i_rst;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic dbg = 1'b0;
  logic idl = 1'b0;
  logic slow;
  logic wd_rst;
  logic [31:0] rdata;
  logic wreq;
  logic irq;
  logic fault;
  logic rall;
  logic rproc;
  logic [11:0] cnt;
  logic [7:0] all_n;
  logic [7:0] proc_n;
  int err_total = 0;
  int checks = 0;
  int tno = 0;
  always #20 i_clk = ~i_clk;
  assign i_rst = por || wd_rst;
  wwd_top #(.PRE_DIV(2)) wwd_top_i (.i_clk(i_clk), .i_rst(i_rst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_slow_clk(slow),
    .i_debug_state(dbg), .i_idle_mode(idl), .o_irq(irq), .o_fault(fault),
    .o_reset_all_req(rall), .o_reset_proc_req(rproc), .o_count(cnt));
  wwd_rstc_model wwd_rstc_model_i (.i_clk(i_clk), .i_reset_all_req(rall),
    .i_reset_proc_req(rproc), .o_slow_clk(slow), .o_wd_rst(wd_rst),
    .o_all_cnt(all_n), .o_proc_cnt(proc_n));
  task tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  task give_up();
    err_total++;
    $display("[ERR] %0t wait timed out", $time);
    tally_and_finish();
  endtask : give_up
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until waitrequest is seen low at a rising edge
  task bus(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge i_clk);
    adr <= a;
    rd <= !w;
    wr <= w;
    wd <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge i_clk);
      if (wreq === 1'b0) break;
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n == 20) give_up();
  endtask : bus
  task wrr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(a, 1'b1, d, q);
  endtask : wrr
  task rdc(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(a, 1'b0, 32'h0, q);
    chk(q, exp);
  endtask : rdc
  task wait_hi(input logic sel);
    int n;
    for (n = 0; n < 3000; n++) begin
      @(posedge i_clk);
      if ((sel ? rproc : irq) === 1'b1) break;
    end
    if (n == 3000) give_up();
  endtask : wait_hi
  task do_rst();
    @(posedge i_clk);
    por <= 1'b1;
    repeat (3) @(posedge i_clk);
    por <= 1'b0;
  endtask : do_rst
  task done();
    tno++;
    $display("test %0d done", tno);
  endtask : done
  initial begin
    do_rst();
    @(negedge i_clk);
    chk(32'(cnt), 32'hfff);
    rdc(4'h4, 32'h3fff_2fff);
    rdc(4'h8, 32'h0);
    rdc(4'hc, 32'h0);
    wrr(4'h0, 32'ha500_0001);
    rdc(4'h8, 32'h0);
    done();
    do_rst();
    wrr(4'h4, 32'h0004_1008);
    @(negedge i_clk);
    chk(32'(cnt), 32'h8);
    wrr(4'h4, 32'h0);
    rdc(4'h4, 32'h0004_1008);
    wrr(4'h0, 32'ha500_0001);
    repeat (2) @(posedge i_clk);
    chk({29'h0, irq, fault, rproc}, 32'h6);
    rdc(4'h8, 32'h2);
    rdc(4'h8, 32'h0);
    chk({31'h0, fault}, 32'h0);
    repeat (80) @(posedge i_clk);
    wrr(4'h0, 32'h5a00_0001);
    @(negedge i_clk);
    chk({31'h0, cnt < 12'h8}, 32'h1);
    wrr(4'h0, 32'ha500_0001);
    @(negedge i_clk);
    chk(32'(cnt), 32'h8);
    rdc(4'h8, 32'h0);
    wait_hi(1'b0);
    chk({30'h0, fault, rproc}, 32'h0);
    rdc(4'h8, 32'h1);
    done();
    for (int k = 0; k < 2; k++) begin
      do_rst();
      wrr(4'h4, k ? 32'h0fff_6003 : 32'h0fff_2003);
      wait_hi(1'b1);
      chk({30'h0, irq, rall}, k ? 32'h0 : 32'h1);
      repeat (8) @(posedge i_clk);
      rdc(4'h4, 32'h3fff_2fff);
    end
    chk({16'h0, all_n, proc_n}, 32'h0101);
    done();
    for (int k = 0; k < 3; k++) begin
      do_rst();
      dbg <= k == 0;
      idl <= k == 1;
      wrr(4'h4, k == 0 ? 32'h1004_0010 : k == 1 ? 32'h2004_0010 : 32'h0004_8010);
      repeat (64) @(posedge i_clk);
      chk(32'(cnt), 32'h10);
      if (k == 2) begin
        wrr(4'h0, 32'ha500_0001);
        rdc(4'h8, 32'h2);
      end else begin
        dbg <= 1'b0;
        idl <= 1'b0;
        repeat (64) @(posedge i_clk);
        chk({31'h0, cnt < 12'h10}, 32'h1);
      end
    end
    done();
    tally_and_finish();
  end
endmodule : wwd_top_tb
